// ==== hdl/afp_top.v ====
// Notes on behaviour
// - Stabilizer locks to encode rising edge, tuned for 100 to 250 MSPS.
// - Stabilizer loop inactive below about 70 MHz encode clock.
// - Samples invalid for 5 us after encode clock rate is raised.
// - Four-level select pin picks output format and stabilizer enable.
// - Zero input gives code 128; twos complement inverts the MSB.
// - Overrange saturates to full-scale codes in either format.
// - Codes rise monotonically, one code per 4 mV step.
// - A forwarded data clock accompanies the data, tracking its delay.
// - Power-down pin high holds the device in low-power state.
// - Powered down, data and data clock outputs are high impedance.
// - Power-down entry takes one cycle, recovery takes three cycles.
`timescale 1ns/10ps
`include "afp_defines.vh"
module afp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ff;
    reg [AW-1:0]    rd_ff;
    reg [AW:0]      cnt_ff;
    wire            push;
    wire            pop;
    assign in_ready_o  = (cnt_ff != DEPTH[AW:0]);
    assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ff];
    always @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wr_ff] <= in_data_i;
        end
    end
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ff  <= {AW{1'b0}};
            rd_ff  <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ff <= (wr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                         : wr_ff + 1'b1;
            end
            if (pop)
            begin
                rd_ff <= (rd_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                         : rd_ff + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_ff <= cnt_ff + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule

module afp_top #(
    parameter SETTLE_CYC = `AFP_SETTLE_CYC,
    parameter LATENCY    = 3,
    parameter FDEPTH     = `AFP_FIFO_DEPTH
) (
    input  wire       MCLK_I,
    input  wire       RST_I,
    input  wire       ENC_CLK_I,
    input  wire [7:0] SAMPLE_I,
    input  wire       OVER_POS_I,
    input  wire       OVER_NEG_I,
    input  wire [1:0] FORMAT_STABILIZER_SELECT_PIN_I,
    input  wire       POWERDOWN_REQUEST_PIN_I,
    input  wire       RATE_UP_I,
    output wire [7:0] DATA_O,
    output wire [7:0] DATA_OE_O,
    output wire       FORWARDED_DATA_CLOCK_O,
    output wire       FORWARDED_DATA_CLOCK_OE_O,
    output wire       DATA_VALID_O,
    output wire       DCS_ENABLE_O,
    output wire       TWOS_COMPLEMENT_O,
    output wire       POWERED_DOWN_O,
    output wire       FIFO_READY_O
);
    localparam ST_RUN  = 2'h0;
    localparam ST_DOWN = 2'h1;
    localparam ST_WAKE = 2'h2;

    reg  [2:0]  enc_sync_ff;
    reg  [1:0]  pd_sync_ff;
    reg  [1:0]  ru_sync_ff;
    reg         ru_last_ff;
    reg  [1:0]  sel_s0_ff;
    reg  [1:0]  sel_s1_ff;
    reg  [9:0]  raw_s0_ff;
    reg  [9:0]  raw_s1_ff;
    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [1:0]  wake_cnt_ff;
    reg  [12:0] settle_ff;
    reg  [7:0]  pipe_ff [0:LATENCY-1];
    reg  [LATENCY-1:0] pvld_ff;
    reg         dclk_ff;
    reg  [7:0]  out_ff;
    reg         valid_ff;
    reg         tc_ff;
    reg         dcs_ff;
    wire        enc_rise;
    wire        active;
    wire        f_valid;
    wire [7:0]  f_data;
    wire        f_ready;
    wire [1:0]  mode;

    // Decodes the quantised select level into format and stabilizer.
    function [1:0] afp_mode;
        input [1:0] lvl;
        begin
            case (lvl)
                `AFP_SEL_OB_DCS_OFF: afp_mode = 2'h0;
                `AFP_SEL_OB_DCS_ON:  afp_mode = 2'h1;
                `AFP_SEL_TC_DCS_ON:  afp_mode = 2'h3;
                default:             afp_mode = 2'h2;
            endcase
        end
    endfunction

    // Output coding with saturation; MSB inverted for twos complement.
    function [7:0] afp_code;
        input [7:0] raw;
        input       pos;
        input       neg;
        input       tc;
        reg   [7:0] ob;
        begin
            ob = pos ? `AFP_FULL_POS : (neg ? `AFP_FULL_NEG : raw);
            afp_code = {ob[7] ^ tc, ob[6:0]};
        end
    endfunction

    assign enc_rise = enc_sync_ff[1] && !enc_sync_ff[2];
    assign active   = (state_ff == ST_RUN);
    assign mode     = afp_mode(sel_s1_ff);

    always @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            enc_sync_ff <= 3'h0;
            pd_sync_ff  <= 2'h0;
            ru_sync_ff  <= 2'h0;
            ru_last_ff  <= 1'b0;
            sel_s0_ff   <= `AFP_SEL_OB_DCS_OFF;
            sel_s1_ff   <= `AFP_SEL_OB_DCS_OFF;
            raw_s0_ff   <= {2'h0, `AFP_MIDSCALE};
            raw_s1_ff   <= {2'h0, `AFP_MIDSCALE};
        end
        else
        begin
            enc_sync_ff <= {enc_sync_ff[1:0], ENC_CLK_I};
            pd_sync_ff  <= {pd_sync_ff[0], POWERDOWN_REQUEST_PIN_I};
            ru_sync_ff  <= {ru_sync_ff[0], RATE_UP_I};
            ru_last_ff  <= ru_sync_ff[1];
            sel_s0_ff   <= FORMAT_STABILIZER_SELECT_PIN_I;
            sel_s1_ff   <= sel_s0_ff;
            raw_s0_ff   <= {OVER_POS_I, OVER_NEG_I, SAMPLE_I};
            raw_s1_ff   <= raw_s0_ff;
        end
    end

    always @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            tc_ff  <= 1'b0;
            dcs_ff <= 1'b0;
        end
        else
        begin
            tc_ff  <= mode[1];
            dcs_ff <= mode[0];
        end
    end

    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN:  if (pd_sync_ff[1] && enc_rise) nxt_state = ST_DOWN;
            ST_DOWN: if (!pd_sync_ff[1]) nxt_state = ST_WAKE;
            ST_WAKE:
            begin
                if (pd_sync_ff[1])
                    nxt_state = ST_DOWN;
                else if (enc_rise && wake_cnt_ff == `AFP_PD_EXIT_CYC - 1)
                    nxt_state = ST_RUN;
            end
            default: nxt_state = ST_DOWN;
        endcase
    end

    always @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            state_ff    <= ST_RUN;
            wake_cnt_ff <= 2'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (state_ff != ST_WAKE)
                wake_cnt_ff <= 2'h0;
            else if (enc_rise)
                wake_cnt_ff <= wake_cnt_ff + 2'h1;
        end
    end

    always @(posedge MCLK_I)
    begin
        if (RST_I)
            settle_ff <= 13'h0000;
        else if (ru_sync_ff[1] && !ru_last_ff)
            settle_ff <= SETTLE_CYC[12:0];
        else if (settle_ff != 13'h0000)
            settle_ff <= settle_ff - 13'h0001;
    end

    genvar gi;
    generate
        for (gi = 0; gi < LATENCY; gi = gi + 1)
        begin : g_pipe
            always @(posedge MCLK_I)
            begin
                if (RST_I)
                begin
                    pipe_ff[gi] <= `AFP_MIDSCALE;
                    pvld_ff[gi] <= 1'b0;
                end
                else if (enc_rise)
                begin
                    if (gi == 0)
                    begin
                        pipe_ff[gi] <= afp_code(raw_s1_ff[7:0],
                                                raw_s1_ff[9],
                                                raw_s1_ff[8], tc_ff);
                        pvld_ff[gi] <= active && (settle_ff == 13'h0000);
                    end
                    else
                    begin
                        pipe_ff[gi] <= pipe_ff[gi-1];
                        pvld_ff[gi] <= pvld_ff[gi-1];
                    end
                end
            end
        end
    endgenerate

    afp_fifo #(
        .WIDTH (8),
        .DEPTH (FDEPTH),
        .AW    (3)
    ) u_fifo (
        .clk_i       (MCLK_I),
        .rst_i       (RST_I),
        .in_valid_i  (enc_rise && pvld_ff[LATENCY-1]),
        .in_ready_o  (f_ready),
        .in_data_i   (pipe_ff[LATENCY-1]),
        .out_valid_o (f_valid),
        .out_ready_i (enc_rise && active),
        .out_data_o  (f_data)
    );

    always @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            out_ff   <= `AFP_MIDSCALE;
            valid_ff <= 1'b0;
            dclk_ff  <= 1'b0;
        end
        else
        begin
            dclk_ff <= enc_sync_ff[1];
            if (enc_rise && active)
            begin
                out_ff   <= f_valid ? f_data : out_ff;
                valid_ff <= f_valid;
            end
            else if (!active)
                valid_ff <= 1'b0;
        end
    end

    assign DATA_OE_O                 = {8{active}};
    assign FORWARDED_DATA_CLOCK_OE_O = active;
    assign DATA_O                    = out_ff;
    assign FORWARDED_DATA_CLOCK_O    = dclk_ff;
    assign DATA_VALID_O              = valid_ff;
    assign DCS_ENABLE_O              = dcs_ff;
    assign TWOS_COMPLEMENT_O         = tc_ff;
    assign POWERED_DOWN_O            = !active;
    assign FIFO_READY_O              = f_ready;
endmodule

// ==== pkg/afp_defines.vh ====
`ifndef AFP_DEFINES_VH
`define AFP_DEFINES_VH
// Mode select levels, two-bit quantised pin reading.
`define AFP_SEL_OB_DCS_OFF  2'h3
`define AFP_SEL_OB_DCS_ON   2'h2
`define AFP_SEL_TC_DCS_ON   2'h1
`define AFP_SEL_TC_DCS_OFF  2'h0
`define AFP_MIDSCALE        8'h80
`define AFP_FULL_POS        8'hFF
`define AFP_FULL_NEG        8'h00
`define AFP_PD_ENTRY_CYC    1
`define AFP_PD_EXIT_CYC     3
// Settling time after a clock rate increase, in ns.
`define AFP_SETTLE_NS       5000
`define AFP_CLK_NS          50
`define AFP_SETTLE_CYC      ((`AFP_SETTLE_NS + `AFP_CLK_NS - 1) / `AFP_CLK_NS)
// Stabilizer window, in MSPS.
`define AFP_DCS_MIN_MSPS    100
`define AFP_DCS_MAX_MSPS    250
`define AFP_DCS_LOOP_MHZ    70
`define AFP_FIFO_DEPTH      8
`endif

// ==== bench/afp_rx_model.sv ====
`timescale 1ns/10ps
module afp_rx_model (
    input  logic       clk_i,
    input  logic [7:0] data_i,
    input  logic [7:0] oe_i,
    input  logic       dco_i,
    input  logic       dco_oe_i,
    input  logic       valid_i,
    output logic       stb_o,
    output logic [7:0] word_o
);
    logic [7:0] line_ff;
    logic       dco_ff;
    wire  [7:0] line = (oe_i == 8'hFF) ? data_i : ~line_ff;
    always @(posedge clk_i)
    begin
        line_ff <= line;
        dco_ff  <= dco_i && dco_oe_i;
        // capture on falling clock, valid only.
        // arrival order kept, so outside logic may compare streams.
        stb_o   <= dco_ff && !(dco_i && dco_oe_i) && valid_i;
        word_o  <= line;
    end
endmodule

// ==== bench/afp_chk.sv ====
`timescale 1ns/10ps
module afp_chk #(
    parameter SETTLE_CYC = 100
) (
    input logic       MCLK_I,
    input logic       RST_I,
    input logic [1:0] FORMAT_STABILIZER_SELECT_PIN_I,
    input logic       POWERDOWN_REQUEST_PIN_I,
    input logic       RATE_UP_I,
    input logic [7:0] DATA_OE_O,
    input logic       FORWARDED_DATA_CLOCK_OE_O,
    input logic       DATA_VALID_O,
    input logic       DCS_ENABLE_O,
    input logic       TWOS_COMPLEMENT_O,
    input logic       POWERED_DOWN_O
);
    default clocking @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);
    logic [4:0] hold_ff;
    logic [7:0] settle_ff;
    logic       rate_ff;
    wire  [1:0] sel = FORMAT_STABILIZER_SELECT_PIN_I;
    wire        pdn = POWERDOWN_REQUEST_PIN_I;
    wire        pd  = POWERED_DOWN_O;
    always @(posedge MCLK_I)
    begin
        rate_ff <= RATE_UP_I;
        if (RST_I || !pdn)
            hold_ff <= 5'h00;
        else if (hold_ff != 5'h1F)
            hold_ff <= hold_ff + 5'h01;
        if (RST_I)
            settle_ff <= 8'h00;
        else if (RATE_UP_I && !rate_ff)
            settle_ff <= 8'h01;
        else if (settle_ff != 8'h00 && settle_ff != 8'hFF)
            settle_ff <= settle_ff + 8'h01;
    end
    a_oe_down:
        assert property (pd && $past(pd) |-> DATA_OE_O == 8'h00)
        else $error("outputs driven while down");
    a_oe_run:
        assert property (!pd && !$past(pd) |-> DATA_OE_O == 8'hFF)
        else $error("outputs idle while running");
    a_dco_oe:
        assert property (FORWARDED_DATA_CLOCK_OE_O == DATA_OE_O[0])
        else $error("clock enable differs from data");
    a_dcs_mode:
        assert property (DCS_ENABLE_O ==
            ($past(sel, 3) == 2'h2 || $past(sel, 3) == 2'h1))
        else $error("stabilizer enable wrong");
    a_twos_mode:
        assert property (TWOS_COMPLEMENT_O == !$past(sel[1], 3))
        else $error("output format wrong");
    a_pd_entry:
        assert property ($rose(pdn) |-> ##[1:16] pd)
        else $error("power-down entry late");
    a_pd_hold:
        assert property (hold_ff > 5'h10 |-> pd)
        else $error("left power-down while requested");
    a_pd_exit:
        assert property ($fell(pdn) && pd |-> pd[*8] ##[1:40] !pd)
        else $error("recovery timing wrong");
    a_settle_quiet:
        assert property (settle_ff > 8'h3C && settle_ff < SETTLE_CYC
            |-> !DATA_VALID_O)
        else $error("valid data while settling");
    cover property ($rose(pd));
    cover property (DATA_VALID_O && TWOS_COMPLEMENT_O && DCS_ENABLE_O);
    cover property (settle_ff == 8'h3D);
endmodule
bind afp_top afp_chk #(.SETTLE_CYC(SETTLE_CYC)) chk (.MCLK_I, .RST_I,
    .FORMAT_STABILIZER_SELECT_PIN_I, .POWERDOWN_REQUEST_PIN_I, .RATE_UP_I,
    .DATA_OE_O, .FORWARDED_DATA_CLOCK_OE_O, .DATA_VALID_O, .DCS_ENABLE_O,
    .TWOS_COMPLEMENT_O, .POWERED_DOWN_O);

// ==== bench/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    logic       mclk = 0, rst = 1, enc = 0, ovp = 0, ovn = 0;
    logic       pdn = 0, rup = 0, rec = 0, enc_q = 0, np, nn;
    logic [1:0] sel = 2'h3;
    logic [7:0] smp = 8'h80, nv;
    logic [7:0] expq[$], gotq[$];
    logic [7:0] corn[6] = '{8'h80, 8'h00, 8'hFF, 8'h7F, 8'h81, 8'h01};
    wire  [7:0] dat, oe, word;
    wire        forwarded_data_clock, dco_oe, vld, duty_cycle_stabilizer, tc, pd, stb, fifo_rdy;
    int         fails = 0, checked = 0, cyc = 0, ecnt = 0, n = 0, k, n0;
    afp_top #(.SETTLE_CYC(100)) uut (.MCLK_I(mclk), .RST_I(rst),
        .ENC_CLK_I(enc), .SAMPLE_I(smp), .OVER_POS_I(ovp), .OVER_NEG_I(ovn),
        .FORMAT_STABILIZER_SELECT_PIN_I(sel), .POWERDOWN_REQUEST_PIN_I(pdn),
        .RATE_UP_I(rup), .DATA_O(dat), .DATA_OE_O(oe),
        .FORWARDED_DATA_CLOCK_O(forwarded_data_clock), .FORWARDED_DATA_CLOCK_OE_O(dco_oe),
        .DATA_VALID_O(vld), .DCS_ENABLE_O(duty_cycle_stabilizer), .TWOS_COMPLEMENT_O(tc),
        .POWERED_DOWN_O(pd), .FIFO_READY_O(fifo_rdy));
    afp_rx_model rx (.clk_i(mclk), .data_i(dat), .oe_i(oe), .dco_i(forwarded_data_clock),
        .dco_oe_i(dco_oe), .valid_i(vld), .stb_o(stb), .word_o(word));
    initial forever #25 mclk = ~mclk;
    initial
    begin
        #13;
        forever #200 enc = ~enc;
    end
    function automatic logic [7:0] code(logic [7:0] r, logic p, q, t);
        logic [7:0] v;
        v = p ? 8'hFF : (q ? 8'h00 : r);
        return t ? {~v[7], v[6:0]} : v;
    endfunction
    function automatic bit found();
        for (int i = 0; i + expq.size() <= gotq.size(); i++)
        begin
            int j = 0;
            while (j < expq.size() && gotq[i+j] === expq[j])
                j++;
            if (j == expq.size() && j > 0)
                return 1;
        end
        return 0;
    endfunction
    task automatic check(string nm, logic [7:0] seen, logic [7:0] want);
        checked++;
        if (seen !== want)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic conclude();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic run_mode(logic [1:0] lv);
        sel <= lv;
        repeat (60) @(posedge mclk);
        check("dcs", duty_cycle_stabilizer, lv == 2'h2 || lv == 2'h1);
        check("twos", tc, !lv[1]);
        @(negedge mclk);
        gotq.delete();
        expq.delete();
        @(posedge mclk);
        rec <= 1;
        repeat (100) @(posedge mclk);
        rec <= 0;
        repeat (80) @(posedge mclk);
        check("stream", found(), 1);
        $display("mode %0d done", lv);
    endtask
    always @(posedge mclk)
    begin
        enc_q <= enc;
        ecnt  <= (enc && !enc_q) ? 0 : ecnt + 1;
        cyc   <= cyc + 1;
        if (stb)
            gotq.push_back(word);
        if (!rec)
            n <= 0;
        if (ecnt == 5)
        begin
            k  = $urandom % 8;
            nv = n < 6 ? corn[n] : 8'($urandom);
            np = n == 6 || (n > 7 && k == 0);
            nn = n == 7 || (n > 7 && k == 1);
            smp <= nv;
            ovp <= np;
            ovn <= nn;
            if (rec)
            begin
                n <= n + 1;
                expq.push_back(code(nv, np, nn, !sel[1]));
            end
        end
        if (cyc == 5000)
        begin
            fails++;
            conclude();
        end
    end
    initial
    begin
        void'($urandom(32'hFA67FCBD));
        repeat (20) @(posedge mclk);
        rst <= 0;
        for (int m = 3; m >= 0; m--)
            run_mode(2'(m));
        pdn <= 1;
        repeat (30) @(posedge mclk);
        check("pd", pd, 1);
        check("oe", oe, 8'h00);
        check("dco_oe", dco_oe, 0);
        pdn <= 0;
        repeat (60) @(posedge mclk);
        check("oe_run", oe, 8'hFF);
        $display("power-down done");
        rup <= 1;
        repeat (60) @(posedge mclk);
        rup <= 0;
        n0 = gotq.size();
        repeat (36) @(posedge mclk);
        check("settle", gotq.size() == n0, 1);
        repeat (80) @(posedge mclk);
        check("resume", gotq.size() > n0, 1);
        check("fifo_ready", fifo_rdy, 1);
        $display("rate change done");
        conclude();
    end
endmodule
